// ---- rtl/serial_eeprom_bus_slave.sv ----
// Purpose: slave side of a two-wire serial memory with self-timed page writes
// Assumes: scl is the link clock; sda is open drain, split into in/out/enable
// Notes:   start and stop are caught on sda edges; the write timer runs on clk

`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_bus_slave #(
	parameter int WC_CYCLES = eeprom_pkg::WC_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       scl,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       wp,
	input  wire logic [2:0] dev_sel
);

	localparam logic [eeprom_pkg::TMR_W-1:0] WC_LAST = (eeprom_pkg::TMR_W)'(WC_CYCLES - 1);

	// ----------------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------------
	logic [7:0]                        mem_r [0:eeprom_pkg::MEM_BYTES-1];
	logic [7:0]                        pg_r  [0:eeprom_pkg::PAGE_BYTES-1];
	logic                              mem_we;
	logic [eeprom_pkg::ADDR_W-1:0]     mem_wa;
	logic                              pg_we;
	logic [eeprom_pkg::PAGE_W-1:0]     pg_idx;
	logic [7:0]                        pg_data;

	// ----------------------------------------------------------------------
	// start / stop detection on sda edges
	// ----------------------------------------------------------------------
	logic start_tgl_r;
	logic start_tgl_nxt;
	logic stop_tgl_r;
	logic stop_tgl_nxt;

	always_comb begin
		start_tgl_nxt = scl ? ~start_tgl_r : start_tgl_r;
		stop_tgl_nxt  = scl ? ~stop_tgl_r : stop_tgl_r;
	end

	always_ff @(negedge sda_in or negedge reset_n) begin
		if (!reset_n) begin
			start_tgl_r <= 1'b0;
		end else begin
			start_tgl_r <= start_tgl_nxt;
		end
	end

	always_ff @(posedge sda_in or negedge reset_n) begin
		if (!reset_n) begin
			stop_tgl_r <= 1'b0;
		end else begin
			stop_tgl_r <= stop_tgl_nxt;
		end
	end

	// ----------------------------------------------------------------------
	// link domain: byte engine on scl rising edges
	// ----------------------------------------------------------------------
	eeprom_pkg::link_state_type    st_r,       st_nxt;
	logic [3:0]                    cnt_r,      cnt_nxt;
	logic [6:0]                    sh_r,       sh_nxt;
	logic                          ack_ok_r,   ack_ok_nxt;
	logic [eeprom_pkg::ADDR_W-1:0] addr_r,     addr_nxt;
	logic [7:0]                    tx_r,       tx_nxt;
	logic                          arm_r,      arm_nxt;
	logic [eeprom_pkg::PAGE_BYTES-1:0] vld_r,  vld_nxt;
	logic [eeprom_pkg::BASE_W-1:0] base_r,     base_nxt;
	logic                          s_seen_r,   s_seen_nxt;
	logic                          p_seen_r,   p_seen_nxt;
	logic [1:0]                    en_q_r;
	logic [1:0]                    wp_q_r;
	logic [2:0]                    sel_q1_r,   sel_q2_r;
	logic                          en_r;
	logic [7:0]                    byte_in;
	logic                          new_frame;
	logic                          stop_pend;
	logic                          sel_match;

	always_comb begin
		byte_in    = {sh_r, sda_in};
		new_frame  = start_tgl_r ^ s_seen_r;
		stop_pend  = stop_tgl_r ^ p_seen_r;
		sel_match  = (byte_in[eeprom_pkg::TYPE_MSB:eeprom_pkg::TYPE_LSB]
			== eeprom_pkg::DEV_TYPE_CODE)
			&& (byte_in[eeprom_pkg::SEL_MSB:eeprom_pkg::SEL_LSB] == sel_q2_r);
		st_nxt     = st_r;
		cnt_nxt    = cnt_r;
		sh_nxt     = sh_r;
		ack_ok_nxt = ack_ok_r;
		addr_nxt   = addr_r;
		tx_nxt     = tx_r;
		arm_nxt    = arm_r;
		vld_nxt    = vld_r;
		base_nxt   = base_r;
		s_seen_nxt = s_seen_r;
		p_seen_nxt = p_seen_r;
		pg_we      = 1'b0;
		pg_idx     = addr_r[eeprom_pkg::PAGE_W-1:0];
		pg_data    = byte_in;
		if (new_frame) begin
			s_seen_nxt = start_tgl_r;
			p_seen_nxt = stop_tgl_r;
			arm_nxt    = 1'b0;
			sh_nxt     = {sh_r[5:0], sda_in};
			cnt_nxt    = eeprom_pkg::BIT_ONE;
			st_nxt     = eeprom_pkg::LK_DEVSEL;
		end else if (stop_pend) begin
			p_seen_nxt = stop_tgl_r;
			arm_nxt    = 1'b0;
			st_nxt     = eeprom_pkg::LK_IDLE;
		end else if (st_r != eeprom_pkg::LK_IDLE) begin
			arm_nxt = arm_r && (cnt_r == eeprom_pkg::BIT_FIRST);
			if (cnt_r != eeprom_pkg::BIT_ACK) begin
				sh_nxt  = {sh_r[5:0], sda_in};
				cnt_nxt = cnt_r + eeprom_pkg::BIT_ONE;
				if (st_r == eeprom_pkg::LK_RDATA) begin
					tx_nxt = {tx_r[6:0], 1'b0};
				end
			end
			if (cnt_r == eeprom_pkg::BIT_LAST) begin
				ack_ok_nxt = 1'b1;
				case (st_r)
					eeprom_pkg::LK_DEVSEL: begin
						ack_ok_nxt = sel_match && en_q_r[1];
					end
					eeprom_pkg::LK_ADDR_HI: begin
						addr_nxt[eeprom_pkg::ADDR_W-1:8] = byte_in[eeprom_pkg::HI_W-1:0];
					end
					eeprom_pkg::LK_ADDR_LO: begin
						addr_nxt[7:0] = byte_in;
					end
					eeprom_pkg::LK_WDATA: begin
						pg_we   = 1'b1;
						vld_nxt[addr_r[eeprom_pkg::PAGE_W-1:0]] = 1'b1;
						base_nxt = addr_r[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W];
						addr_nxt[eeprom_pkg::PAGE_W-1:0] =
							addr_r[eeprom_pkg::PAGE_W-1:0] + 1'b1;
					end
					default: begin
						ack_ok_nxt = 1'b0;
					end
				endcase
			end
			if (cnt_r == eeprom_pkg::BIT_ACK) begin
				cnt_nxt = eeprom_pkg::BIT_FIRST;
				case (st_r)
					eeprom_pkg::LK_DEVSEL: begin
						if (!ack_ok_r) begin
							st_nxt = eeprom_pkg::LK_IDLE;
						end else if (sh_r[0]) begin
							st_nxt   = eeprom_pkg::LK_RDATA;
							tx_nxt   = mem_r[addr_r];
							addr_nxt = addr_r + 1'b1;
						end else begin
							st_nxt  = eeprom_pkg::LK_ADDR_HI;
							vld_nxt = '0;
						end
					end
					eeprom_pkg::LK_ADDR_HI: begin
						st_nxt = eeprom_pkg::LK_ADDR_LO;
					end
					eeprom_pkg::LK_ADDR_LO: begin
						st_nxt = eeprom_pkg::LK_WDATA;
					end
					eeprom_pkg::LK_WDATA: begin
						arm_nxt = !wp_q_r[1];
					end
					eeprom_pkg::LK_RDATA: begin
						if (!sda_in) begin
							tx_nxt   = mem_r[addr_r];
							addr_nxt = addr_r + 1'b1;
						end else begin
							st_nxt = eeprom_pkg::LK_IDLE;
						end
					end
					default: begin
						st_nxt = eeprom_pkg::LK_IDLE;
					end
				endcase
			end
		end
	end

	// toggles, page latches and pins are stable around scl edges by protocol
	always_ff @(posedge scl or negedge reset_n) begin
		if (!reset_n) begin
			st_r     <= eeprom_pkg::LK_IDLE;
			cnt_r    <= eeprom_pkg::BIT_FIRST;
			sh_r     <= '0;
			ack_ok_r <= 1'b0;
			addr_r   <= '0;
			tx_r     <= '0;
			arm_r    <= 1'b0;
			vld_r    <= '0;
			base_r   <= '0;
			s_seen_r <= 1'b0;
			p_seen_r <= 1'b0;
			en_q_r   <= '0;
			wp_q_r   <= '0;
			sel_q1_r <= '0;
			sel_q2_r <= '0;
		end else begin
			st_r     <= st_nxt;
			cnt_r    <= cnt_nxt;
			sh_r     <= sh_nxt;
			ack_ok_r <= ack_ok_nxt;
			addr_r   <= addr_nxt;
			tx_r     <= tx_nxt;
			arm_r    <= arm_nxt;
			vld_r    <= vld_nxt;
			base_r   <= base_nxt;
			s_seen_r <= s_seen_nxt;
			p_seen_r <= p_seen_nxt;
			en_q_r   <= {en_q_r[0], en_r};
			wp_q_r   <= {wp_q_r[0], wp};
			sel_q1_r <= dev_sel;
			sel_q2_r <= sel_q1_r;
		end
	end

	always_ff @(posedge scl) begin
		if (pg_we) begin
			pg_r[pg_idx] <= pg_data;
		end
	end

	// ----------------------------------------------------------------------
	// link domain: sda drive on scl falling edges
	// ----------------------------------------------------------------------
	logic drv_r;
	logic drv_nxt;

	always_comb begin
		drv_nxt = 1'b0;
		if (st_r == eeprom_pkg::LK_RDATA) begin
			if (cnt_r != eeprom_pkg::BIT_ACK) begin
				drv_nxt = !tx_r[7];
			end
		end else if (st_r != eeprom_pkg::LK_IDLE) begin
			drv_nxt = (cnt_r == eeprom_pkg::BIT_ACK) && ack_ok_r;
		end
	end

	always_ff @(negedge scl or negedge reset_n) begin
		if (!reset_n) begin
			drv_r <= 1'b0;
		end else begin
			drv_r <= drv_nxt;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = drv_r;

	// ----------------------------------------------------------------------
	// system domain: write launch and timer
	// ----------------------------------------------------------------------
	eeprom_pkg::write_state_type      wst_r, wst_nxt;
	logic [eeprom_pkg::TMR_W-1:0]     tmr_r, tmr_nxt;
	logic [2:0]                       stop_q_r;
	logic [1:0]                       arm_q_r;
	logic                             en_nxt;
	logic                             stop_evt;
	logic [eeprom_pkg::PAGE_W-1:0]    slot;

	always_comb begin
		stop_evt = stop_q_r[2] ^ stop_q_r[1];
		slot     = tmr_r[eeprom_pkg::PAGE_W-1:0];
		wst_nxt  = wst_r;
		tmr_nxt  = tmr_r;
		mem_we   = 1'b0;
		mem_wa   = {base_r, slot};
		case (wst_r)
			eeprom_pkg::WR_IDLE: begin
				if (stop_evt && arm_q_r[1]) begin
					wst_nxt = eeprom_pkg::WR_BUSY;
					tmr_nxt = '0;
				end
			end
			default: begin
				tmr_nxt = tmr_r + 1'b1;
				mem_we  = (tmr_r[eeprom_pkg::TMR_W-1:eeprom_pkg::PAGE_W] == '0)
					&& vld_r[slot];
				if (tmr_r == WC_LAST) begin
					wst_nxt = eeprom_pkg::WR_IDLE;
				end
			end
		endcase
		en_nxt = (wst_nxt == eeprom_pkg::WR_IDLE);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wst_r    <= eeprom_pkg::WR_IDLE;
			tmr_r    <= '0;
			stop_q_r <= '0;
			arm_q_r  <= '0;
			en_r     <= 1'b0;
		end else begin
			wst_r    <= wst_nxt;
			tmr_r    <= tmr_nxt;
			stop_q_r <= {stop_q_r[1:0], stop_tgl_r};
			arm_q_r  <= {arm_q_r[0], arm_r};
			en_r     <= en_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem_r[mem_wa] <= pg_r[slot];
		end
	end

endmodule : serial_eeprom_bus_slave

`default_nettype wire

// ---- rtl/eeprom_pkg.sv ----
// Purpose: shared constants and state types of the two-wire serial memory slave
// Assumes: 32K x 8 storage, 64-byte pages, 10 MHz system clock
// Notes:   the device type code below is an arbitrary value

package eeprom_pkg;

	// ----------------------------------------------------------------------
	// storage geometry
	// ----------------------------------------------------------------------
	localparam int ADDR_W     = 15;
	localparam int MEM_BYTES  = 32768;
	localparam int PAGE_BYTES = 64;
	localparam int PAGE_W     = 6;
	localparam int HI_W       = 7;
	localparam int BASE_W     = ADDR_W - PAGE_W;

	// ----------------------------------------------------------------------
	// select byte layout
	// ----------------------------------------------------------------------
	localparam logic [3:0] DEV_TYPE_CODE = 4'h6; // arbitrary value
	localparam int         TYPE_MSB      = 7;
	localparam int         TYPE_LSB      = 4;
	localparam int         SEL_MSB       = 3;
	localparam int         SEL_LSB       = 1;

	// ----------------------------------------------------------------------
	// bit counter positions within a byte frame
	// ----------------------------------------------------------------------
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_LAST  = 4'h7;
	localparam logic [3:0] BIT_ACK   = 4'h8;
	localparam logic [3:0] BIT_ONE   = 4'h1;

	// ----------------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------------
	localparam int CLK_PERIOD_NS                 = 100;
	localparam int NONVOLATILE_WRITE_DURATION_MS = 10;
	localparam int NS_PER_MS                     = 1000000;
	localparam int WC_CYCLES = NONVOLATILE_WRITE_DURATION_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int TMR_W     = 17;

	// ----------------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------------
	typedef enum logic [2:0] {
		LK_IDLE, LK_DEVSEL, LK_ADDR_HI, LK_ADDR_LO, LK_WDATA, LK_RDATA
	} link_state_type;

	typedef enum logic {
		WR_IDLE, WR_BUSY
	} write_state_type;

endpackage : eeprom_pkg

// ---- dv/serial_eeprom_bus_slave_monitor.sv ----
// Purpose: protocol checker for the two-wire memory slave
// Assumes: sees only top ports; sda_in is the resolved wire
// Notes:   frame position is tracked on scl and sda edges
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_bus_slave_monitor #(
	parameter int WC_CYCLES = 100
) (
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       scl,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       wp,
	input wire logic [2:0] dev_sel
);
	// ------------------------------------------------------------------
	// frame tracking
	// ------------------------------------------------------------------
	logic       st_tgl_r, st_seen_r, rw_r, bad_sel;
	logic [3:0] bit_r, byte_r, run_r;
	logic [7:0] sh_r;
	assign bad_sel = sh_r[7:4] != eeprom_pkg::DEV_TYPE_CODE || sh_r[3:1] != dev_sel;
	always_ff @(negedge sda_in or negedge reset_n)
		if (!reset_n) st_tgl_r <= 1'b0;
		else if (scl) st_tgl_r <= ~st_tgl_r;
	always_ff @(negedge scl or negedge reset_n)
		if (!reset_n) run_r <= 4'h0;
		else run_r <= sda_oe ? run_r + 4'h1 : 4'h0;
	always_ff @(posedge scl or negedge reset_n) begin
		if (!reset_n) begin
			st_seen_r <= 1'b0;
			bit_r     <= 4'h0;
			byte_r    <= 4'h0;
			rw_r      <= 1'b0;
			sh_r      <= 8'h00;
		end else begin
			st_seen_r <= st_tgl_r;
			sh_r      <= {sh_r[6:0], sda_in};
			if (st_tgl_r != st_seen_r) begin
				bit_r  <= 4'h1;
				byte_r <= 4'h0;
				rw_r   <= 1'b0;
			end else if (bit_r == 4'h9) begin
				bit_r  <= 4'h1;
				byte_r <= (byte_r == 4'hF) ? byte_r : byte_r + 4'h1;
			end else if (bit_r != 4'h0) begin
				bit_r <= bit_r + 4'h1;
				if (bit_r == 4'h7 && byte_r == 4'h0) rw_r <= sda_in;
			end
		end
	end
	AST_SDA_OUT_LOW: assert property (@(posedge clk) disable iff (!reset_n)
		sda_out == 1'b0) else $error("sda_out not low");
	AST_CHANGE_ON_FALL: assert property (@(scl) disable iff (!reset_n)
		scl |-> $stable(sda_oe)) else $error("sda drive changed while scl high");
	AST_FRAME_QUIET: assert property (@(posedge scl) disable iff (!reset_n)
		st_tgl_r != st_seen_r |-> !sda_oe) else $error("drive right after start");
	AST_WRITE_ONLY_ACK: assert property (@(posedge scl) disable iff (!reset_n)
		sda_oe && !rw_r |-> bit_r == 4'h8) else $error("write drive outside ack");
	AST_NO_ACK_MISMATCH: assert property (@(posedge scl) disable iff (!reset_n)
		bit_r == 4'h8 && byte_r == 4'h0 && bad_sel |-> !sda_oe) else $error("bad select acked");
	AST_READ_RELEASE: assert property (@(posedge scl) disable iff (!reset_n)
		bit_r == 4'h8 && byte_r != 4'h0 && rw_r |-> !sda_oe) else $error("no release for ack");
	AST_NACK_IDLE: assert property (@(posedge scl) disable iff (!reset_n)
		bit_r == 4'h8 && byte_r != 4'h0 && rw_r && sda_in |=> !sda_oe) else $error("drive after nack");
	AST_DRIVE_RUN: assert property (@(posedge scl) disable iff (!reset_n)
		run_r <= 4'h9) else $error("sda held low too long");
	cover property (@(posedge scl) bit_r == 4'h8 && byte_r == 4'h0 && sda_oe);
	cover property (@(posedge scl) bit_r == 4'h8 && byte_r == 4'h0 && bad_sel);
	cover property (@(posedge scl) bit_r == 4'h8 && byte_r != 4'h0 && rw_r && sda_in);
endmodule : serial_eeprom_bus_slave_monitor
`default_nettype wire

// ---- dv/two_wire_master_model.sv ----
// Purpose: two-wire bus master that clocks scl and pulls sda low
// Assumes: sda has a pull-up; scl stands high between frames
// Notes:   link clock period 6 ns
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model (
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	// ------------------------------------------------------------------
	// bus conditions and byte transfers
	// ------------------------------------------------------------------
	initial begin
		scl     = 1'b1;
		sda_low = 1'b0;
	end
	task automatic start_cond();
		#1 sda_low = 1'b0;
		#2 scl = 1'b1;
		#3 sda_low = 1'b1;
		#3 scl = 1'b0;
	endtask : start_cond
	task automatic stop_cond();
		#1 sda_low = 1'b1;
		#2 scl = 1'b1;
		#3 sda_low = 1'b0;
		#3;
	endtask : stop_cond
	// data moves 1 ns after scl falls, never in the same time step
	task automatic tick(input logic low);
		#1 sda_low = low;
		#2 scl = 1'b1;
		#3 scl = 1'b0;
	endtask : tick
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) tick(~b[i]);
		#1 sda_low = 1'b0;
		#2 scl = 1'b1;
		ack = ~sda;
		#3 scl = 1'b0;
	endtask : send_byte
	task automatic recv_byte(input logic ack_it, output logic [7:0] b);
		#1 sda_low = 1'b0;
		for (int i = 0; i < 8; i++) begin
			#2 scl = 1'b1;
			b = {b[6:0], sda};
			#3 scl = 1'b0;
			if (i < 7) #1;
		end
		tick(ack_it);
	endtask : recv_byte
endmodule : two_wire_master_model
`default_nettype wire

// ---- dv/serial_eeprom_bus_slave_test.sv ----
// Purpose: self-checking bench for the two-wire memory slave
// Assumes: write timer shortened to 100 clk cycles
// Notes:   reset_n and wp change on the falling clk edge; scl and sda follow the master model delays
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_bus_slave_test;
	// ------------------------------------------------------------------
	// environment
	// ------------------------------------------------------------------
	localparam logic [2:0] PINS = 3'h5;
	localparam logic [7:0] WSEL = {eeprom_pkg::DEV_TYPE_CODE, PINS, 1'b0};
	localparam logic [7:0] RSEL = {eeprom_pkg::DEV_TYPE_CODE, PINS, 1'b1};
	logic       clk, reset_n, wp, sda_out, sda_oe, scl, sda_low, ack;
	logic [2:0] dev_sel;
	logic [7:0] rd;
	wire        sda;
	int         fail_count, comparisons, cycles;
	assign sda = ((sda_oe && !sda_out) || sda_low) ? 1'b0 : 1'b1;
	serial_eeprom_bus_slave #(.WC_CYCLES(100)) dut (.clk(clk), .reset_n(reset_n),
		.scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp),
		.dev_sel(dev_sel));
	two_wire_master_model m (.scl(scl), .sda_low(sda_low), .sda(sda));
	initial clk = 1'b0;
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			complete_run();
		end
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic complete_run();
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	task automatic put(input logic [7:0] b, input logic exp_ack);
		m.send_byte(b, ack);
		check({7'h0, ack}, {7'h0, exp_ack});
	endtask : put
	task automatic get(input logic ack_it, input logic [7:0] exp);
		m.recv_byte(ack_it, rd);
		check(rd, exp);
	endtask : get
	task automatic fin();
		m.stop_cond();
		repeat (4) @(negedge clk);
	endtask : fin
	task automatic point(input logic [14:0] a);
		m.start_cond();
		put(WSEL, 1'b1);
		put({1'b0, a[14:8]}, 1'b1);
		put(a[7:0], 1'b1);
	endtask : point
	task automatic rsel_frame();
		m.start_cond();
		put(RSEL, 1'b1);
	endtask : rsel_frame
	task automatic poll_done();
		int n;
		n = 0;
		ack = 1'b0;
		while (!ack && n < 30) begin
			repeat (10) @(negedge clk);
			m.start_cond();
			m.send_byte(WSEL, ack);
			m.stop_cond();
			n++;
		end
		check({7'h0, ack}, 8'h01);
		check((n >= 10 && n <= 12) ? 8'h01 : 8'h00, 8'h01);
	endtask : poll_done
	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic s_select();
		m.start_cond();
		put({eeprom_pkg::DEV_TYPE_CODE, PINS ^ 3'h1, 1'b0}, 1'b0);
		fin();
		m.start_cond();
		put({~eeprom_pkg::DEV_TYPE_CODE, PINS, 1'b1}, 1'b0);
		fin();
	endtask : s_select
	task automatic s_page();
		point(15'h7FBE);
		for (int i = 0; i < 4; i++) put(8'hA0 + 8'(i), 1'b1);
		fin();
		poll_done();
		point(15'h7FBE);
		rsel_frame();
		get(1'b0, 8'hA0);
		fin();
		rsel_frame();
		get(1'b0, 8'hA1);
		fin();
		point(15'h7F80);
		rsel_frame();
		get(1'b1, 8'hA2);
		get(1'b0, 8'hA3);
		fin();
	endtask : s_page
	task automatic s_wrap();
		point(15'h7FFF);
		put(8'h5A, 1'b1);
		fin();
		poll_done();
		point(15'h0000);
		put(8'hC3, 1'b1);
		fin();
		poll_done();
		point(15'h7FFF);
		rsel_frame();
		get(1'b1, 8'h5A);
		get(1'b0, 8'hC3);
		fin();
	endtask : s_wrap
	task automatic s_wait();
		point(15'h0001);
		put(8'h3C, 1'b1);
		fin();
		repeat (110) @(negedge clk);
		point(15'h0001);
		rsel_frame();
		get(1'b0, 8'h3C);
		fin();
	endtask : s_wait
	task automatic s_protect();
		@(negedge clk) wp = 1'b1;
		point(15'h7F80);
		put(8'h11, 1'b1);
		fin();
		m.start_cond();
		put(WSEL, 1'b1);
		fin();
		@(negedge clk) wp = 1'b0;
		point(15'h7F81);
		put(8'h22, 1'b1);
		m.tick(1'b0);
		fin();
		m.start_cond();
		put(WSEL, 1'b1);
		fin();
		point(15'h7F80);
		rsel_frame();
		get(1'b1, 8'hA2);
		get(1'b0, 8'hA3);
		fin();
	endtask : s_protect
	initial begin
		reset_n     = 1'b0;
		wp          = 1'b0;
		dev_sel     = PINS;
		fail_count  = 0;
		comparisons = 0;
		cycles      = 0;
		m.start_cond();
		put(WSEL, 1'b0);
		m.stop_cond();
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		repeat (2) @(negedge clk);
		s_select();
		s_page();
		s_wrap();
		s_wait();
		s_protect();
		complete_run();
	end
endmodule : serial_eeprom_bus_slave_test
bind serial_eeprom_bus_slave serial_eeprom_bus_slave_monitor #(.WC_CYCLES(WC_CYCLES)) mon (
	.clk(clk), .reset_n(reset_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .wp(wp), .dev_sel(dev_sel));
`default_nettype wire
